//--- hdl/osc_ctrl.sv
// Function
// - lock flag only when tuned within 1%
// - out-of-range flag follows trim range need
// - writable next_source in request bits 6:4
// - writable next_divider in request bits 3:0
// - reserved source code discards whole write
// - request read-only when switching not allowed
// - next_source resets from configuration strap
// - current_source read-only in bits 6:4
// - current_divider read-only in bits 3:0
// - hold pauses switch once source ready
// - secondary power select drives crystal mode
// - switch_done when request equals current
// - new_source_ready only while pending and ready
// - unheld switch completes cycle after ready
// - freq_trim signed six bits, zero reset
// - frequency select codes above eight reserved
// - external ready only when enabled, ready
// - internal ready flags when enabled, ready
// - secondary and adc ready when enabled, ready
// - pll ready when enabled, sourced, locked
// - auto tune owns trim, ignores writes
// - tune irq on lock or range change
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module osc_ctrl
    import osc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // configuration straps, stable while running
    input wire logic [2:0] reset_source_cfg,
    input wire logic clock_switch_allow,
    // raw oscillator status (asynchronous)
    input wire logic [7:0] osc_ready_raw,
    input wire logic [7:0] osc_enabled_raw,
    input wire logic pll_source_ready_raw,
    input wire logic pll_locked_raw,
    // auto tuner results (asynchronous)
    input wire logic tuner_locked_raw,
    input wire logic tuner_out_of_range_raw,
    input wire logic tuner_update,
    input wire logic [5:0] tuner_trim,
    // clock mux control
    output logic [2:0] clk_source_sel,
    output logic [3:0] clk_divider_sel,
    output logic secondary_power_sel,
    output logic [5:0] freq_trim,
    output logic [3:0] hf_freq_select,
    output logic auto_tune_irq_flag
);
    // reserved source code test, used on software writes to the request
    function automatic logic src_reserved(input logic [2:0] s);
        src_reserved = OSC_SRC_RSVD_MASK[s];
    endfunction : src_reserved

    logic [17:0] sync_in; // packed raw inputs
    logic [17:0] sync_q; // synchronised copy
    logic [7:0] rdy_s;
    logic [7:0] en_s;
    logic pll_src_s;
    logic pll_lock_s;
    logic [1:0] tune_s; // lock, range after sync
    assign sync_in = {osc_ready_raw, osc_enabled_raw, pll_source_ready_raw, pll_locked_raw};
    osc_sync #(.W(18)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(sync_in),
        .sync_out(sync_q)
    );
    assign {rdy_s, en_s, pll_src_s, pll_lock_s} = sync_q;

    logic [1:0] tune_m_q; // first stage of tuner status sync
    logic [1:0] tune_q; // second stage
    logic upd_m_q; // tuner update strobe sync
    logic upd_q;
    logic upd_prev_q;
    logic [5:0] trim_m_q; // tuner trim word, first stage
    logic [5:0] trim_s_q; // tuner trim word, second stage
    // tuner signals cross from the tuning clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tune_m_q <= 2'h0;
            tune_q <= 2'h0;
            upd_m_q <= 1'b0;
            upd_q <= 1'b0;
            upd_prev_q <= 1'b0;
            trim_m_q <= 6'h00;
            trim_s_q <= 6'h00;
        end else begin
            tune_m_q <= {tuner_locked_raw, tuner_out_of_range_raw};
            tune_q <= tune_m_q;
            upd_m_q <= tuner_update;
            upd_q <= upd_m_q;
            upd_prev_q <= upd_q;
            trim_m_q <= tuner_trim;
            trim_s_q <= trim_m_q;
        end
    end
    assign tune_s = tune_q;

    // apb decode: one-wait-free access, address is index times four
    logic acc_wr;
    logic acc_rd;
    logic [7:0] widx;
    logic hit;
    assign acc_wr = psel && penable && pwrite && pstrb[0];
    assign acc_rd = psel && penable && !pwrite;
    assign widx = paddr[9:2];
    assign hit = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0) &&
                 (widx >= OSC_IDX_TUNE_CTRL) && (widx <= OSC_IDX_STATUS);

    logic strap_done_q; // straps captured after reset release
    logic [2:0] next_source_q;
    logic [3:0] next_divider_q;
    logic [2:0] cur_source_q;
    logic [3:0] cur_divider_q;
    logic switch_hold_q;
    logic spwr_q;
    logic [5:0] trim_q;
    logic [3:0] freq_q;
    logic aten_q;
    logic tune_upd_dis_q; // software update disable
    logic lock_q;
    logic ors_q;
    logic irq_q;
    osc_sw_e sw_q;
    logic pending;
    assign pending = (next_source_q != cur_source_q) || (next_divider_q != cur_divider_q);

    // request register; straps load after release, never under async reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_done_q <= 1'b0;
            next_source_q <= 3'h0;
            next_divider_q <= OSC_DIV_RST;
        end else if (!strap_done_q) begin
            strap_done_q <= 1'b1;
            next_source_q <= reset_source_cfg;
        end else if (!clock_switch_allow) begin
            next_source_q <= reset_source_cfg;
            next_divider_q <= OSC_DIV_RST;
        end else if (acc_wr && widx == OSC_IDX_REQUEST) begin
            // a reserved source drops the divider too
            if (!src_reserved(pwdata[OSC_SRC_LSB +: 3])) begin
                next_source_q <= pwdata[OSC_SRC_LSB +: 3];
                next_divider_q <= pwdata[OSC_DIV_LSB +: 4];
            end
        end
    end

    // switch sequencer: wait for the target ready, optionally hold, then change over
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_q <= OSC_IDLE;
            cur_source_q <= 3'h0;
            cur_divider_q <= OSC_DIV_RST;
        end else if (!strap_done_q) begin
            cur_source_q <= reset_source_cfg;
        end else begin
            case (sw_q)
                OSC_IDLE: begin
                    if (pending) begin
                        sw_q <= OSC_WAIT;
                    end
                end
                OSC_WAIT: begin
                    // readiness of the oscillator whose ready bit matches the code
                    if (!pending) begin
                        sw_q <= OSC_IDLE;
                    end else if (rdy_s[next_source_q]) begin
                        sw_q <= OSC_READY;
                    end
                end
                OSC_READY: begin
                    if (!pending || !rdy_s[next_source_q]) begin
                        sw_q <= pending ? OSC_WAIT : OSC_IDLE;
                    end else if (!switch_hold_q) begin
                        // one cycle after ready, then change over
                        cur_source_q <= next_source_q;
                        cur_divider_q <= next_divider_q;
                        sw_q <= OSC_IDLE;
                    end
                end
                default: sw_q <= OSC_IDLE;
            endcase
        end
    end

    // switch control register writable bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_hold_q <= 1'b0;
            spwr_q <= 1'b0;
        end else if (acc_wr && widx == OSC_IDX_SWITCH) begin
            switch_hold_q <= pwdata[OSC_HOLD_BIT];
            spwr_q <= pwdata[OSC_SPWR_BIT];
        end
    end

    // frequency select; reserved codes are refused, value kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_q <= OSC_FREQ_RST;
        end else if (acc_wr && widx == OSC_IDX_FREQ && pwdata[3:0] <= OSC_FREQ_MAX) begin
            freq_q <= pwdata[3:0];
        end
    end

    // tuning control bits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aten_q <= 1'b0;
            tune_upd_dis_q <= 1'b0;
        end else if (acc_wr && widx == OSC_IDX_TUNE_CTRL) begin
            aten_q <= pwdata[OSC_ATEN_BIT];
            tune_upd_dis_q <= pwdata[OSC_ATEN_BIT - 1];
        end
    end

    // trim: hardware owns it under auto tune, software otherwise
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trim_q <= OSC_TRIM_RST;
        end else if (aten_q) begin
            // trim word runs through two flops beside its strobe, so both arrive together
            if (upd_q && !upd_prev_q && !tune_upd_dis_q) begin
                trim_q <= trim_s_q;
            end
        end else if (acc_wr && widx == OSC_IDX_TRIM && !tune_upd_dis_q) begin
            trim_q <= pwdata[5:0];
        end
    end

    // lock and range status; only meaningful while tuning is on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_q <= 1'b0;
            ors_q <= 1'b0;
        end else begin
            lock_q <= aten_q && tune_s[1];
            ors_q <= aten_q && tune_s[0];
        end
    end

    // tune event flag: hardware set beats a software clear in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_q <= 1'b0;
        end else if (aten_q && ((tune_s[1] != lock_q) || (tune_s[0] != ors_q))) begin
            irq_q <= 1'b1;
        end else if (acc_wr && widx == OSC_IDX_TUNE_CTRL && pwdata[0]) begin
            irq_q <= 1'b0; // write one to bit 0 clears
        end
    end

    // status word: each flag needs enable and ready
    logic [7:0] status_w;
    always_comb begin
        status_w = 8'h00;
        status_w[OSC_RDY_EXT] = en_s[OSC_RDY_EXT] && rdy_s[OSC_RDY_EXT];
        status_w[OSC_RDY_HF] = en_s[OSC_RDY_HF] && rdy_s[OSC_RDY_HF];
        status_w[OSC_RDY_MF] = en_s[OSC_RDY_MF] && rdy_s[OSC_RDY_MF];
        status_w[OSC_RDY_LF] = en_s[OSC_RDY_LF] && rdy_s[OSC_RDY_LF];
        status_w[OSC_RDY_SECONDARY_XTAL] = en_s[OSC_RDY_SECONDARY_XTAL] && rdy_s[OSC_RDY_SECONDARY_XTAL];
        status_w[OSC_RDY_ADC] = en_s[OSC_RDY_ADC] && rdy_s[OSC_RDY_ADC];
        status_w[OSC_RDY_PLL] = en_s[OSC_RDY_PLL] && pll_src_s && pll_lock_s;
    end

    // read mux
    logic [7:0] rd_w;
    always_comb begin
        rd_w = 8'h00;
        case (widx)
            OSC_IDX_TUNE_CTRL: begin
                rd_w[OSC_ATEN_BIT] = aten_q;
                rd_w[OSC_ATEN_BIT - 1] = tune_upd_dis_q;
                rd_w[OSC_LOCK_BIT] = lock_q;
                rd_w[OSC_ORS_BIT] = ors_q;
                rd_w[0] = irq_q;
            end
            OSC_IDX_REQUEST: rd_w = {1'b0, next_source_q, next_divider_q};
            OSC_IDX_CURRENT: rd_w = {1'b0, cur_source_q, cur_divider_q};
            OSC_IDX_SWITCH: begin
                rd_w[OSC_HOLD_BIT] = switch_hold_q;
                rd_w[OSC_SPWR_BIT] = spwr_q;
                rd_w[OSC_DONE_BIT] = !pending;
                rd_w[OSC_NRDY_BIT] = pending && (sw_q == OSC_READY);
            end
            OSC_IDX_TRIM: rd_w = {2'h0, trim_q};
            OSC_IDX_FREQ: rd_w = {4'h0, freq_q};
            OSC_IDX_STATUS: rd_w = status_w;
            default: rd_w = 8'h00;
        endcase
    end

    // apb response registers: ready on the access cycle's setup edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            prdata <= (psel && !penable && !pwrite && hit) ? {24'h00_0000, rd_w} : 32'h0000_0000;
        end
    end

    // clock mux outputs: source and divider follow the current selection, the rest their control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clk_source_sel <= 3'h0;
            clk_divider_sel <= OSC_DIV_RST;
            secondary_power_sel <= 1'b0;
            freq_trim <= OSC_TRIM_RST;
            hf_freq_select <= OSC_FREQ_RST;
            auto_tune_irq_flag <= 1'b0;
        end else begin
            clk_source_sel <= cur_source_q;
            clk_divider_sel <= cur_divider_q;
            secondary_power_sel <= spwr_q;
            freq_trim <= trim_q;
            hf_freq_select <= freq_q;
            auto_tune_irq_flag <= irq_q;
        end
    end
    logic unused_rd; // acc_rd kept for clarity of decode
    assign unused_rd = acc_rd;
endmodule : osc_ctrl
`default_nettype wire

//--- hdl/osc_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser bank for the asynchronous oscillator status inputs
module osc_sync #(
    parameter int W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_q; // first stage, read only by the second
    // shift through two stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_q <= '0;
            sync_out <= '0;
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule : osc_sync
`default_nettype wire

//--- pkg/osc_pkg.sv
package osc_pkg;
    // register word indices; the byte address on the bus is the index times four
    localparam logic [7:0] OSC_IDX_TUNE_CTRL = 8'hAC;
    localparam logic [7:0] OSC_IDX_REQUEST = 8'hAD;
    localparam logic [7:0] OSC_IDX_CURRENT = 8'hAE;
    localparam logic [7:0] OSC_IDX_SWITCH = 8'hAF;
    localparam logic [7:0] OSC_IDX_TRIM = 8'hB0;
    localparam logic [7:0] OSC_IDX_FREQ = 8'hB1;
    localparam logic [7:0] OSC_IDX_STATUS = 8'hB2;
    // field positions
    localparam int OSC_SRC_LSB = 4;
    localparam int OSC_DIV_LSB = 0;
    localparam int OSC_HOLD_BIT = 7;
    localparam int OSC_SPWR_BIT = 6;
    localparam int OSC_DONE_BIT = 4;
    localparam int OSC_NRDY_BIT = 3;
    localparam int OSC_ATEN_BIT = 7;
    localparam int OSC_LOCK_BIT = 3;
    localparam int OSC_ORS_BIT = 1;
    // reset values and the highest legal frequency code
    localparam logic [3:0] OSC_DIV_RST = 4'h0;
    localparam logic [5:0] OSC_TRIM_RST = 6'h00;
    localparam logic [3:0] OSC_FREQ_RST = 4'h0;
    localparam logic [3:0] OSC_FREQ_MAX = 4'h8;
    // a source code is reserved when its reserved-mask bit is set (plain default)
    localparam logic [7:0] OSC_SRC_RSVD_MASK = 8'h48;
    // ready-status bit positions
    localparam int OSC_RDY_EXT = 7;
    localparam int OSC_RDY_HF = 6;
    localparam int OSC_RDY_MF = 5;
    localparam int OSC_RDY_LF = 4;
    localparam int OSC_RDY_SECONDARY_XTAL = 3;
    localparam int OSC_RDY_ADC = 2;
    localparam int OSC_RDY_PLL = 0;
    // switch sequencer states
    typedef enum logic [1:0] {OSC_IDLE, OSC_WAIT, OSC_READY} osc_sw_e;
endpackage : osc_pkg

//--- testbench/osc_ctrl_chk.sv
`timescale 1ns/100ps
`default_nettype none
// watches the apb slave and the clock control outputs of osc_ctrl
module osc_ctrl_chk
    import osc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [2:0] reset_source_cfg,
    input wire logic clock_switch_allow,
    input wire logic [2:0] clk_source_sel,
    input wire logic secondary_power_sel,
    input wire logic [3:0] hf_freq_select,
    input wire logic auto_tune_irq_flag
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // word index and map decode; the map is one contiguous run of words
    wire logic [7:0] idx = paddr[9:2];
    wire logic mapped = paddr[1:0] == 2'b00 && paddr[11:10] == 2'b00 &&
        idx >= OSC_IDX_TUNE_CTRL && idx <= OSC_IDX_STATUS;
    // completed low-byte write
    wire logic wr0 = pready && pwrite && pstrb[0] && mapped;

    ready_pulse_a: assert property (pready |=> !pready) else $error("pready held too long");
    ready_setup_a: assert property (psel && !penable |=> pready) else $error("wait state seen");
    ready_access_a: assert property (pready |-> psel && penable) else $error("stray pready");
    err_unmapped_a: assert property (pready && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    byte_mapped_a: assert property (pready && mapped |-> !pslverr && prdata[31:8] == 24'h0)
        else $error("mapped access answered badly");
    spwr_write_a: assert property (wr0 && idx == OSC_IDX_SWITCH |-> ##2
        secondary_power_sel == $past(pwdata[OSC_SPWR_BIT], 2))
        else $error("power mode not taken");
    freq_write_a: assert property (wr0 && idx == OSC_IDX_FREQ |-> ##2 hf_freq_select ==
        ($past(pwdata[3:0], 2) <= OSC_FREQ_MAX ? $past(pwdata[3:0], 2) :
        $past(hf_freq_select, 2))) else $error("frequency select write wrong");
    freq_range_a: assert property (hf_freq_select <= OSC_FREQ_MAX) else $error("reserved freq");
    req_locked_a: assert property (pready && !pwrite && idx == OSC_IDX_REQUEST && mapped &&
        !clock_switch_allow && !$past(clock_switch_allow, 2) |->
        prdata[6:0] == {reset_source_cfg, 4'h0}) else $error("locked request changed");

    // main scenarios reached
    cover property (wr0 && idx == OSC_IDX_REQUEST);
    cover property ($changed(clk_source_sel));
    cover property ($rose(auto_tune_irq_flag));
    cover property (pslverr);
endmodule : osc_ctrl_chk

bind osc_ctrl osc_ctrl_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .reset_source_cfg, .clock_switch_allow,
    .clk_source_sel, .secondary_power_sel, .hf_freq_select, .auto_tune_irq_flag);
`default_nettype wire

//--- testbench/oscillator_select_and_status_tb.sv
`timescale 1ns/100ps
`default_nettype none
// register-level bench for osc_ctrl over apb
module oscillator_select_and_status_tb
    import osc_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'hF, hf_freq_select, clk_divider_sel, fexp;
    logic pready, pslverr, err, secondary_power_sel, auto_tune_irq_flag;
    logic [2:0] reset_source_cfg = 3'h2, clk_source_sel; // strap source 2
    logic clock_switch_allow = 1'b0, pll_source_ready_raw = 1'b0, pll_locked_raw = 1'b0;
    logic [7:0] osc_ready_raw = 8'h06, osc_enabled_raw = 8'h00; // sources 1, 2 ready
    logic tuner_locked_raw = 1'b0, tuner_out_of_range_raw = 1'b0, tuner_update = 1'b0;
    logic [5:0] tuner_trim = 6'h00, freq_trim;
    int fails = 0, cmp_count = 0, cycles = 0;
    // status table: enables, readies, pll lock, expected status
    logic [7:0] t_en [4] = '{8'hF0, 8'h0D, 8'h0D, 8'hFF};
    logic [7:0] t_rdy [4] = '{8'hFF, 8'hFF, 8'hFF, 8'h00};
    logic t_lck [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    logic [7:0] t_exp [4] = '{8'hF0, 8'h0D, 8'h0C, 8'h01};

    osc_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .reset_source_cfg, .clock_switch_allow, .osc_ready_raw,
        .osc_enabled_raw, .pll_source_ready_raw, .pll_locked_raw, .tuner_locked_raw,
        .tuner_out_of_range_raw, .tuner_update, .tuner_trim, .clk_source_sel, .clk_divider_sel,
        .secondary_power_sel, .freq_trim, .hf_freq_select, .auto_tune_irq_flag);

    // free-running 100 MHz clock
    initial begin
        forever #5 pclk = ~pclk;
    end

    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 4000) begin
            fails++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("Error %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; answer is taken in the cycle pready stands high
    // request held until the rising edge that sees pready, released right after it
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask : rchk

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        // reset values
        rchk(OSC_IDX_STATUS, 8'h00);
        rchk(OSC_IDX_TRIM, 8'h00);
        rchk(OSC_IDX_REQUEST, 8'h20);
        // switching forbidden: request stays at the strap
        xfer(1'b1, OSC_IDX_REQUEST, 8'h15);
        rchk(OSC_IDX_REQUEST, 8'h20);
        clock_switch_allow <= 1'b1;
        // plain switch to source 1, divider 5
        xfer(1'b1, OSC_IDX_REQUEST, 8'h15);
        rchk(OSC_IDX_REQUEST, 8'h15);
        repeat (8) @(posedge pclk);
        rchk(OSC_IDX_CURRENT, 8'h15);
        chk({clk_source_sel, clk_divider_sel}, 7'h15);
        rchk(OSC_IDX_SWITCH, 8'h10);
        // reserved source code drops the whole write
        xfer(1'b1, OSC_IDX_REQUEST, 8'h37);
        rchk(OSC_IDX_REQUEST, 8'h15);
        // held switch to source 4 whose oscillator is not yet ready
        xfer(1'b1, OSC_IDX_SWITCH, 8'h80);
        xfer(1'b1, OSC_IDX_REQUEST, 8'h42);
        rchk(OSC_IDX_SWITCH, 8'h80);
        osc_ready_raw <= 8'h16;
        repeat (8) @(posedge pclk);
        rchk(OSC_IDX_SWITCH, 8'h88);
        rchk(OSC_IDX_CURRENT, 8'h15);
        xfer(1'b1, OSC_IDX_SWITCH, 8'h00);
        repeat (8) @(posedge pclk);
        rchk(OSC_IDX_CURRENT, 8'h42);
        rchk(OSC_IDX_SWITCH, 8'h10);
        // secondary crystal power mode
        // register then output flop: the pin follows two edges after the write
        xfer(1'b1, OSC_IDX_SWITCH, 8'h40);
        repeat (2) @(posedge pclk);
        chk(secondary_power_sel, 1'b1);
        xfer(1'b1, OSC_IDX_SWITCH, 8'h00);
        repeat (2) @(posedge pclk);
        chk(secondary_power_sel, 1'b0);
        // every frequency code; reserved ones leave the last legal one
        fexp = 4'h0;
        for (int i = 0; i < 16; i++) begin
            xfer(1'b1, OSC_IDX_FREQ, 8'(i));
            if (i <= 8) fexp = 4'(i);
            repeat (2) @(posedge pclk);
            chk(hf_freq_select, fexp);
        end
        // signed trim extremes by software
        xfer(1'b1, OSC_IDX_TRIM, 8'h20);
        repeat (2) @(posedge pclk);
        chk(freq_trim, 6'h20);
        xfer(1'b1, OSC_IDX_TRIM, 8'h1F);
        rchk(OSC_IDX_TRIM, 8'h1F);
        // auto tune owns the trim; software writes are ignored
        xfer(1'b1, OSC_IDX_TUNE_CTRL, 8'h80);
        xfer(1'b1, OSC_IDX_TRIM, 8'h05);
        rchk(OSC_IDX_TRIM, 8'h1F);
        tuner_trim <= 6'h0A;
        tuner_update <= 1'b1;
        repeat (6) @(posedge pclk);
        chk(freq_trim, 6'h0A);
        rchk(OSC_IDX_TUNE_CTRL, 8'h80);
        // lock and range changes raise the flag; write one clears it
        tuner_locked_raw <= 1'b1;
        repeat (6) @(posedge pclk);
        rchk(OSC_IDX_TUNE_CTRL, 8'h89);
        chk(auto_tune_irq_flag, 1'b1);
        xfer(1'b1, OSC_IDX_TUNE_CTRL, 8'h81);
        rchk(OSC_IDX_TUNE_CTRL, 8'h88);
        chk(auto_tune_irq_flag, 1'b0);
        tuner_out_of_range_raw <= 1'b1;
        repeat (6) @(posedge pclk);
        rchk(OSC_IDX_TUNE_CTRL, 8'h8B);
        // ready flags need both enable and ready; pll also its lock
        pll_source_ready_raw <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            osc_enabled_raw <= t_en[i];
            osc_ready_raw <= t_rdy[i];
            pll_locked_raw <= t_lck[i];
            repeat (4) @(posedge pclk);
            rchk(OSC_IDX_STATUS, t_exp[i]);
        end
        // word outside the map is refused
        xfer(1'b0, 8'hB3, 8'h00);
        chk(err, 1'b1);
        chk(rd, 32'h0000_0000);
        end_of_test();
    end
endmodule : oscillator_select_and_status_tb
`default_nettype wire
